// File: gpab_regs.vh
/*
 * register offsets, widths and reset values of the three-port gpio block.
 * assumes a byte-wide register bus with 4-bit addresses inside the block.
 */
`ifndef GPAB_REGS_VH
`define GPAB_REGS_VH

`define GPAB_ADDR_W        4
`define GPAB_OFF_PA_DATA   4'h0
`define GPAB_OFF_PB_DATA   4'h1
`define GPAB_OFF_PC_DATA   4'h2
`define GPAB_OFF_PA_DIR    4'h4
`define GPAB_OFF_PB_DIR    4'h5
`define GPAB_OFF_PC_DIR    4'h6
`define GPAB_OFF_PA_PUE    4'hD
`define GPAB_OFF_PC_PUE    4'hE
`define GPAB_OFF_ADC_SEL   4'h9
`define GPAB_PA_W          4
`define GPAB_PB_W          6
`define GPAB_PC_W          2
`define GPAB_DIR_RST_PA    4'h0
`define GPAB_DIR_RST_PB    6'h00
`define GPAB_DIR_RST_PC    2'h0
`define GPAB_PUE_RST_PA    4'h0
`define GPAB_PUE_RST_PC    2'h0
`define GPAB_ADC_OFF       3'h7

`endif

// File: gpab_ports.v
/*
 * gpio logic for the keyboard-shared, converter-shared and plain two-bit ports.
 * assumes pins synchronous to clk and a master that never issues both strobes.
 */
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
`include "gpab_regs.vh"

// Function
// R1: one software data latch per pin; reset leaves the latches untouched.
// R2: direction one drives latch onto pin; direction zero makes pin an input.
// R3: keyboard port has four pins; reset clears its direction to inputs.
// R4: keyboard port data read gives latch for outputs, pin level for inputs.
// R5: data writes always update latch, whatever the direction; inputs unaffected.
// R6: converter port data read gives latch for outputs, pin for inputs.
// R7: keyboard pullup only when enabled and direction input; output disables it.
// R8: keyboard irq enables make the keyboard port pins interrupt inputs.
// R9: converter port has six pins; selected analog channel overrides pin logic.
// R10: converter direction at its address, bits 5..0, reset to inputs, 7..6 zero.
// R11: third port has two pins, one latch each, pullups when inputs; code gives an input its pullup only where its enable bit at 4'hE is set.
// R12: software should load latch before switching a pin to output.
// R13: two-bit port data read gives latch for outputs, pin for inputs.
// R14: writes land on the strobe edge; unimplemented bits ignore writes, read zero.
module gpab_ports (
    input  wire                    clk,
    input  wire                    rst,
    input  wire [`GPAB_ADDR_W-1:0] addr,
    input  wire [7:0]              wdata,
    input  wire                    wr_en,
    input  wire                    rd_en,
    output reg  [7:0]              rdata_ff,
    input  wire [3:0]              pa_in,
    output reg  [3:0]              pa_out_ff,
    output reg  [3:0]              pa_oe_n_ff,
    output reg  [3:0]              pa_pullup_ff,
    input  wire [5:0]              pb_in,
    output reg  [5:0]              pb_out_ff,
    output reg  [5:0]              pb_oe_n_ff,
    output reg  [5:0]              pb_analog_ff,
    input  wire [1:0]              pc_in,
    output reg  [1:0]              pc_out_ff,
    output reg  [1:0]              pc_oe_n_ff,
    output reg  [1:0]              pc_pullup_ff,
    input  wire [3:0]              keyboard_pin_irq_enables,
    output reg  [3:0]              keyboard_inputs_ff
);

    // latches have no reset on purpose; contents survive a system reset
    reg [3:0] port_a_data_latch_ff;
    reg [5:0] port_b_data_latch_ff;
    reg [1:0] port_c_data_latch_ff;
    reg [3:0] port_a_direction_ff;
    reg [5:0] port_b_direction_ff;
    reg [1:0] port_c_direction_ff;
    reg [3:0] port_a_pullup_enable_ff;
    reg [1:0] port_c_pullup_enable_ff;
    reg [2:0] adc_sel_ff;
    reg [5:0] nxt_analog;
    reg [7:0] nxt_rdata;

    always @(posedge clk)
    begin
        if (wr_en && addr == `GPAB_OFF_PA_DATA)
            port_a_data_latch_ff <= wdata[3:0]; // [R1] [R5] [R14]
        if (wr_en && addr == `GPAB_OFF_PB_DATA)
            port_b_data_latch_ff <= wdata[5:0]; // [R1] [R5] [R9]
        if (wr_en && addr == `GPAB_OFF_PC_DATA)
            port_c_data_latch_ff <= wdata[1:0]; // [R1] [R5] [R11]
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            port_a_direction_ff     <= `GPAB_DIR_RST_PA; // [R3]
            port_b_direction_ff     <= `GPAB_DIR_RST_PB; // [R10]
            port_c_direction_ff     <= `GPAB_DIR_RST_PC;
            port_a_pullup_enable_ff <= `GPAB_PUE_RST_PA;
            port_c_pullup_enable_ff <= `GPAB_PUE_RST_PC;
            adc_sel_ff              <= `GPAB_ADC_OFF;
        end
        else if (wr_en)
        begin
            case (addr)
                `GPAB_OFF_PA_DIR: port_a_direction_ff     <= wdata[3:0]; // [R14]
                `GPAB_OFF_PB_DIR: port_b_direction_ff     <= wdata[5:0]; // [R10]
                `GPAB_OFF_PC_DIR: port_c_direction_ff     <= wdata[1:0];
                `GPAB_OFF_PA_PUE: port_a_pullup_enable_ff <= wdata[3:0];
                `GPAB_OFF_PC_PUE: port_c_pullup_enable_ff <= wdata[1:0]; // [R11]
                `GPAB_OFF_ADC_SEL: adc_sel_ff             <= wdata[2:0];
                default: ;
            endcase
        end
    end

    // channel codes 6 and 7 select no pin
    always @*
    begin
        nxt_analog = 6'h00;
        if (adc_sel_ff < 3'h6)
            nxt_analog[adc_sel_ff] = 1'b1; // [R9]
    end

    // data reads mix latch and live pin per bit; unmapped addresses read zero
    always @*
    begin
        nxt_rdata = 8'h00;
        case (addr)
            `GPAB_OFF_PA_DATA: nxt_rdata[3:0] = (port_a_direction_ff & port_a_data_latch_ff)
                | (~port_a_direction_ff & pa_in); // [R4]
            `GPAB_OFF_PB_DATA: nxt_rdata[5:0] = (port_b_direction_ff & port_b_data_latch_ff)
                | (~port_b_direction_ff & pb_in); // [R6]
            `GPAB_OFF_PC_DATA: nxt_rdata[1:0] = (port_c_direction_ff & port_c_data_latch_ff)
                | (~port_c_direction_ff & pc_in); // [R13]
            `GPAB_OFF_PA_DIR:  nxt_rdata[3:0] = port_a_direction_ff;
            `GPAB_OFF_PB_DIR:  nxt_rdata[5:0] = port_b_direction_ff; // [R10]
            `GPAB_OFF_PC_DIR:  nxt_rdata[1:0] = port_c_direction_ff;
            `GPAB_OFF_PA_PUE:  nxt_rdata[3:0] = port_a_pullup_enable_ff;
            `GPAB_OFF_PC_PUE:  nxt_rdata[1:0] = port_c_pullup_enable_ff;
            `GPAB_OFF_ADC_SEL: nxt_rdata[2:0] = adc_sel_ff;
            default:           nxt_rdata = 8'h00; // [R14]
        endcase
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_ff           <= 8'h00;
            pa_out_ff          <= 4'h0;
            pa_oe_n_ff         <= 4'hF;
            pa_pullup_ff       <= 4'h0;
            pb_out_ff          <= 6'h00;
            pb_oe_n_ff         <= 6'h3F;
            pb_analog_ff       <= 6'h00;
            pc_out_ff          <= 2'h0;
            pc_oe_n_ff         <= 2'h3;
            pc_pullup_ff       <= 2'h0;
            keyboard_inputs_ff <= 4'h0;
        end
        else
        begin
            rdata_ff     <= rd_en ? nxt_rdata : 8'h00;
            pa_out_ff    <= port_a_data_latch_ff;
            pa_oe_n_ff   <= ~port_a_direction_ff; // [R2]
            pa_pullup_ff <= port_a_pullup_enable_ff & ~port_a_direction_ff; // [R7]
            pb_out_ff    <= port_b_data_latch_ff;
            // analog selection forces the pin off the digital driver
            pb_oe_n_ff   <= ~(port_b_direction_ff & ~nxt_analog); // [R2] [R9]
            pb_analog_ff <= nxt_analog; // [R9]
            pc_out_ff    <= port_c_data_latch_ff;
            pc_oe_n_ff   <= ~port_c_direction_ff; // [R2]
            pc_pullup_ff <= port_c_pullup_enable_ff & ~port_c_direction_ff; // [R11]
            // live level handed to the keyboard logic only where enabled
            keyboard_inputs_ff <= pa_in & keyboard_pin_irq_enables; // [R8]
        end
    end

endmodule

// File: gpab_pins.sv
/* board side of the three ports.
   assumes the bench sets ext to what the board drives. */
`timescale 1ns/10ps
module gpab_pins #(parameter W = 4) (
    input  wire [W-1:0] out, oe_n, pu, ext,
    output wire [W-1:0] lvl
);
    // driving pin wins over pullup, pullup over board
    assign lvl = (~oe_n & out) | (oe_n & pu) | (oe_n & ~pu & ext);
endmodule

// File: gpab_ports_asserts.sv
/* checker of gpab_ports relations.
   assumes binding to the top ports by name. */
`timescale 1ns/10ps
module gpab_ports_asserts (
    input wire       clk, rst, wr_en, rd_en,
    input wire [3:0] addr, pa_in, pa_out_ff, pa_oe_n_ff, pa_pullup_ff,
    input wire [3:0] keyboard_pin_irq_enables, keyboard_inputs_ff,
    input wire [7:0] wdata, rdata_ff,
    input wire [5:0] pb_oe_n_ff, pb_analog_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_rd_idle: assert property (!rd_en |=> rdata_ff == 8'h00)
        else $error("rdata not idle");
    chk_dir_write: assert property (wr_en && addr == 4'h4 ##1 !(wr_en && addr == 4'h4)
        |=> pa_oe_n_ff == ~$past(wdata[3:0], 2)) else $error("dir a lost");
    chk_pull_dir: assert property ((pa_pullup_ff & ~pa_oe_n_ff) == 4'h0)
        else $error("pullup on output");
    chk_kbd_and: assert property (!$past(rst) |-> keyboard_inputs_ff ==
        ($past(pa_in) & $past(keyboard_pin_irq_enables))) else $error("kbd wrong");
    chk_an_oe: assert property ((pb_analog_ff & ~pb_oe_n_ff) == 6'h00)
        else $error("analog pin driven");
    chk_an_hot: assert property ($onehot0(pb_analog_ff))
        else $error("two analog pins");
    chk_dirb_top: assert property (rd_en && addr == 4'h5 |=> rdata_ff[7:6] == 2'h0)
        else $error("dir b top set");
    chk_pa_read: assert property (rd_en && addr == 4'h0 && !$past(wr_en) |=>
        rdata_ff == $past({4'h0, (pa_out_ff & ~pa_oe_n_ff) | (pa_in & pa_oe_n_ff)}))
        else $error("port a read wrong");
    cover property (wr_en && addr == 4'h4);
    cover property (rd_en && addr == 4'h0);
    cover property (|pb_analog_ff);
endmodule

// File: gpab_ports_tb.sv
/* bench of gpab_ports with board model.
   assumes a 25 MHz clock. */
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("wrong value at %0t: %h %h", $time, g, e); end end
module gpab_ports_tb;
    reg clk = 0, rst = 1, wr_en = 0, rd_en = 0;
    reg [3:0] addr = 0, kie = 0;
    reg [7:0] wdata = 0, ext = 0;
    wire [7:0] rd;
    wire [3:0] pai, pao, paoe, papu, kbd;
    wire [5:0] pbi, pbo, pboe, pban;
    wire [1:0] pci, pco, pcoe, pcpu;
    int errors = 0, n_checks = 0, i;
    // addr, dir, latch, board, expected
    logic [39:0] rows [5] = '{40'h00000A0A0A, 40'h0003050809,
        40'h013C152A16, 40'h01013F2121, 40'h0201030001};
    always #20 clk = ~clk;
    gpab_ports uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata_ff(rd), .pa_in(pai), .pa_out_ff(pao), .pa_oe_n_ff(paoe),
        .pa_pullup_ff(papu), .pb_in(pbi), .pb_out_ff(pbo), .pb_oe_n_ff(pboe),
        .pb_analog_ff(pban), .pc_in(pci), .pc_out_ff(pco), .pc_oe_n_ff(pcoe),
        .pc_pullup_ff(pcpu), .keyboard_pin_irq_enables(kie), .keyboard_inputs_ff(kbd));
    gpab_pins #(4) pa (.out(pao), .oe_n(paoe), .pu(papu), .ext(ext[3:0]), .lvl(pai));
    gpab_pins #(6) pb (.out(pbo), .oe_n(pboe), .pu(6'h00), .ext(ext[5:0]), .lvl(pbi));
    gpab_pins #(2) pc (.out(pco), .oe_n(pcoe), .pu(pcpu), .ext(ext[1:0]), .lvl(pci));
    task wr(input [3:0] a, input [7:0] d);
        @(posedge clk);
        wr_en <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 0;
    endtask
    task rdc(input [3:0] a, input [7:0] e);
        @(posedge clk);
        rd_en <= 1;
        addr <= a;
        @(posedge clk);
        rd_en <= 0;
        #1 `CHK(rd, e)
    endtask
    task close_out;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        close_out;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        for (i = 0; i < 5; i++) begin
            ext <= rows[i][15:8];
            wr(rows[i][35:32], rows[i][23:16]);
            wr(rows[i][35:32] + 4'h4, rows[i][31:24]);
            repeat (2) @(posedge clk);
            rdc(rows[i][35:32], rows[i][7:0]);
        end
        $display("rows done");
        wr(4'h4, 8'h00);
        wr(4'hD, 8'hFF);
        ext <= 8'h00;
        kie <= 4'h5;
        repeat (3) @(posedge clk);
        #1 `CHK({papu, kbd}, 8'hF5)
        rdc(4'h0, 8'h0F);
        rdc(4'hD, 8'h0F);
        wr(4'h4, 8'h0F);
        repeat (2) @(posedge clk);
        #1 `CHK(papu, 4'h0)
        wr(4'h5, 8'hFF);
        wr(4'h9, 8'h02);
        repeat (2) @(posedge clk);
        #1 `CHK({pban, pboe}, 12'h104)
        `CHK(pbo, 6'h3F)
        `CHK({pco, pcoe}, 4'hE)
        rdc(4'h5, 8'h3F);
        rdc(4'h3, 8'h00);
        $display("pins done");
        wr(4'h0, 8'h06);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        rdc(4'h4, 8'h00);
        rdc(4'h5, 8'h00);
        `CHK(pban, 6'h00)
        wr(4'h4, 8'h0F);
        repeat (2) @(posedge clk);
        #1 `CHK({pao, paoe}, 8'h60)
        rdc(4'h0, 8'h06);
        wr(4'hE, 8'h03);
        repeat (2) @(posedge clk);
        #1 `CHK(pcpu, 2'h3)
        $display("reset done");
        close_out;
    end
endmodule
bind gpab_ports gpab_ports_asserts chk (.*);
